// *** include/pfs_defines.vh ***
`ifndef PFS_DEFINES_VH
`define PFS_DEFINES_VH
// ==========================================================
// Command codes
`define PFS_CMD_SUMMARY_BYTE 8'h78
`define PFS_CMD_SUMMARY_WORD 8'h79
`define PFS_CMD_VOUT_STATUS 8'h7A
`define PFS_CMD_IOUT_STATUS 8'h7B
`define PFS_CMD_INPUT_STATUS 8'h7C
// ==========================================================
// Number of outputs (pages)
`define PFS_PAGES 2
// ==========================================================
// Summary word bit positions
`define PFS_SW_VOUT 15
`define PFS_SW_IOUT 14
`define PFS_SW_INPUT 13
`define PFS_SW_VENDOR 12
`define PFS_SW_PG_N 11
`define PFS_SW_OTHER 9
`define PFS_SW_BUSY 7
`define PFS_SW_OFF 6
`define PFS_SW_VOUT_OV 5
`define PFS_SW_IOUT_OC 4
`define PFS_SW_VIN_UV 3
`define PFS_SW_TEMP 2
`define PFS_SW_CML 1
`define PFS_SW_NONE 0
// ==========================================================
// Detail register bit positions
`define PFS_VO_OV 7
`define PFS_VO_UV 4
`define PFS_IO_OC 7
`define PFS_IO_UC 4
`define PFS_IN_OV_FAULT 7
`define PFS_IN_OV_WARN 6
`define PFS_IN_UV_WARN 5
`define PFS_IN_UV_FAULT 4
// ==========================================================
// Reset values and answer lengths
`define PFS_RESET_WORD 16'h0000
`define PFS_RESET_BYTE 8'h00
`define PFS_LEN_ONE 2'h1
`define PFS_LEN_TWO 2'h2
`endif

// *** hw/pfs_status_regs.v ***
`timescale 1ns/100ps
`default_nettype none
`include "pfs_defines.vh"

module pfs_status_regs
(
   // Clock and reset
   input wire clk_i,
   input wire srst_i,
   // Command access from the serial engine
   input wire rd_i,
   input wire wr_i,
   input wire [7:0] cmd_i,
   input wire [0:0] page_i,
   // Per-page fault events from the detectors
   input wire [1:0] output_overvoltage_fault_i,
   input wire [1:0] output_undervoltage_fault_i,
   input wire [1:0] output_overcurrent_fault_i,
   input wire [1:0] output_undercurrent_fault_i,
   input wire [1:0] busy_fault_i,
   // Global input supply events
   input wire input_overvoltage_fault_i,
   input wire input_overvoltage_warning_i,
   input wire input_undervoltage_warning_i,
   input wire input_undervoltage_fault_i,
   // Live conditions and summaries of other detail registers
   input wire [1:0] output_off_i,
   input wire [1:0] power_good_i,
   input wire [1:0] temp_any_i,
   input wire comms_memory_logic_flag_i,
   input wire vendor_class_flag_i,
   // Clears all latched status
   input wire clear_faults_i,
   // Read answer
   output reg rd_valid_o,
   output reg rd_hit_o,
   output reg [1:0] rd_len_o,
   output reg [15:0] rd_data_o,
   // Write attempt to a read-only code
   output reg ro_write_err_o
);

   // ==========================================================
   // Latched detail storage
   // Event inputs come from detectors on clk_i, so no synchroniser is placed here
   reg [1:0] vo_ov;
   reg [1:0] vo_uv;
   reg [1:0] io_oc;
   reg [1:0] io_uc;
   reg [1:0] busy;
   reg [3:0] in_st;

   // ==========================================================
   // Detail and summary decode
   function [7:0] vout_byte;
      input ov;
      input uv;
      begin
         vout_byte = `PFS_RESET_BYTE;
         vout_byte[`PFS_VO_OV] = ov;
         vout_byte[`PFS_VO_UV] = uv;
      end
   endfunction

   function [7:0] iout_byte;
      input oc;
      input uc;
      begin
         iout_byte = `PFS_RESET_BYTE;
         iout_byte[`PFS_IO_OC] = oc;
         iout_byte[`PFS_IO_UC] = uc;
      end
   endfunction

   // Input byte holds fault/warning bits in 7:4, zeros below
   function [7:0] input_byte;
      input [3:0] st;
      begin
         input_byte = {st, 4'h0};
      end
   endfunction

   // Sticky update for a per-page pair; the event term is ORed last so it wins
   function [1:0] sticky_pair;
      input [1:0] held;
      input [1:0] event_in;
      input clear;
      begin
         sticky_pair = (clear ? 2'h0 : held) | event_in;
      end
   endfunction

   // Same update for the four global input bits
   function [3:0] sticky_quad;
      input [3:0] held;
      input [3:0] event_in;
      input clear;
      begin
         sticky_quad = (clear ? 4'h0 : held) | event_in;
      end
   endfunction

   // True for the five status codes handled here
   function is_status_code;
      input [7:0] code;
      begin
         is_status_code = (code == `PFS_CMD_SUMMARY_BYTE) |
            (code == `PFS_CMD_SUMMARY_WORD) |
            (code == `PFS_CMD_VOUT_STATUS) |
            (code == `PFS_CMD_IOUT_STATUS) |
            (code == `PFS_CMD_INPUT_STATUS);
      end
   endfunction

   // Computed from live detail bits so summary never lags a detail read
   function [15:0] summary;
      input [7:0] vo;
      input [7:0] io;
      input [7:0] inp;
      input bsy;
      input off;
      input pg;
      input tmp;
      input comms_memory_logic_flag;
      input vnd;
      reg [7:0] low;
      begin
         summary = `PFS_RESET_WORD;
         summary[`PFS_SW_VOUT] = |vo;
         summary[`PFS_SW_IOUT] = |io;
         summary[`PFS_SW_INPUT] = |inp;
         summary[`PFS_SW_VENDOR] = vnd;
         summary[`PFS_SW_PG_N] = ~pg;
         summary[`PFS_SW_OTHER] = (|vo) | (|io) | (|inp) | tmp | comms_memory_logic_flag | vnd;
         summary[`PFS_SW_BUSY] = bsy;
         summary[`PFS_SW_OFF] = off;
         summary[`PFS_SW_VOUT_OV] = vo[`PFS_VO_OV];
         summary[`PFS_SW_IOUT_OC] = io[`PFS_IO_OC];
         summary[`PFS_SW_VIN_UV] = inp[`PFS_IN_UV_FAULT];
         summary[`PFS_SW_TEMP] = tmp;
         summary[`PFS_SW_CML] = comms_memory_logic_flag;
         low = summary[7:0];
         // Anything in bits 15:11 not already shown in bits 7:1
         summary[`PFS_SW_NONE] = (|summary[15:11]) & ~(|low[7:1]);
      end
   endfunction

   // ==========================================================
   // Selected-page views
   wire [7:0] sel_vo;
   wire [7:0] sel_io;
   wire [7:0] sel_in;
   wire [15:0] sel_sw;
   assign sel_vo = vout_byte(vo_ov[page_i], vo_uv[page_i]);
   assign sel_io = iout_byte(io_oc[page_i], io_uc[page_i]);
   assign sel_in = input_byte(in_st);
   // Per-page latched busy bit and live flags picked by the page pointer
   // The page is only meaningful with a read strobe; between reads either page may show
   wire sel_busy;
   wire sel_off;
   wire sel_pg;
   wire sel_tmp;
   assign sel_busy = busy[page_i];
   assign sel_off = output_off_i[page_i];
   assign sel_pg = power_good_i[page_i];
   assign sel_tmp = temp_any_i[page_i];
   assign sel_sw = summary(sel_vo, sel_io, sel_in, sel_busy, sel_off, sel_pg, sel_tmp,
      comms_memory_logic_flag_i, vendor_class_flag_i);

   // One decode serves both the read hit and the write error
   wire own_code;
   assign own_code = is_status_code(cmd_i);

   // ==========================================================
   // Sticky status bits; a new event wins over a same-cycle clear,
   // so a fault that lands on the clear strobe is never lost

   // Output overvoltage, one bit per page
   always @(posedge clk_i)
   begin
      if (srst_i)
         vo_ov <= 2'h0;
      else
         vo_ov <= sticky_pair(vo_ov, output_overvoltage_fault_i, clear_faults_i);
   end

   // Output undervoltage, one bit per page
   always @(posedge clk_i)
   begin
      if (srst_i)
         vo_uv <= 2'h0;
      else
         vo_uv <= sticky_pair(vo_uv, output_undervoltage_fault_i, clear_faults_i);
   end

   // Output overcurrent, one bit per page
   always @(posedge clk_i)
   begin
      if (srst_i)
         io_oc <= 2'h0;
      else
         io_oc <= sticky_pair(io_oc, output_overcurrent_fault_i, clear_faults_i);
   end

   // Output undercurrent, one bit per page
   always @(posedge clk_i)
   begin
      if (srst_i)
         io_uc <= 2'h0;
      else
         io_uc <= sticky_pair(io_uc, output_undercurrent_fault_i, clear_faults_i);
   end

   // Busy fault, one bit per page
   always @(posedge clk_i)
   begin
      if (srst_i)
         busy <= 2'h0;
      else
         busy <= sticky_pair(busy, busy_fault_i, clear_faults_i);
   end

   // Global input bits, shared by both pages
   always @(posedge clk_i)
   begin
      if (srst_i)
         in_st <= 4'h0;
      else
         in_st <= sticky_quad(in_st, {input_overvoltage_fault_i,
            input_overvoltage_warning_i, input_undervoltage_warning_i,
            input_undervoltage_fault_i}, clear_faults_i);
   end

   // ==========================================================
   // Answer decode; unknown codes give no data and length zero
   // Decoded every cycle, only a read strobe lets it into the output flops
   reg next_rd_hit;
   reg [1:0] next_rd_len;
   reg [15:0] next_rd_data;

   always @*
   begin
      next_rd_hit = own_code;
      next_rd_len = `PFS_LEN_ONE;
      next_rd_data = `PFS_RESET_WORD;
      case (cmd_i)
         `PFS_CMD_SUMMARY_BYTE: next_rd_data = {`PFS_RESET_BYTE, sel_sw[7:0]};
         `PFS_CMD_SUMMARY_WORD:
         begin
            next_rd_data = sel_sw;
            next_rd_len = `PFS_LEN_TWO;
         end
         `PFS_CMD_VOUT_STATUS: next_rd_data = {`PFS_RESET_BYTE, sel_vo};
         `PFS_CMD_IOUT_STATUS: next_rd_data = {`PFS_RESET_BYTE, sel_io};
         `PFS_CMD_INPUT_STATUS: next_rd_data = {`PFS_RESET_BYTE, sel_in};
         default: next_rd_len = 2'h0; // Unknown code: no data
      endcase
   end

   // ==========================================================
   // Read answer, one cycle after the strobe; writes only set ro_write_err_o
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         rd_valid_o <= 1'h0;
         rd_hit_o <= 1'h0;
         rd_len_o <= 2'h0;
         rd_data_o <= `PFS_RESET_WORD;
         ro_write_err_o <= 1'h0;
      end
      else
      begin
         rd_valid_o <= rd_i;
         ro_write_err_o <= wr_i & own_code;
         // Fields hold until the next read so a slow host can still fetch them
         if (rd_i)
         begin
            rd_hit_o <= next_rd_hit;
            rd_len_o <= next_rd_len;
            rd_data_o <= next_rd_data;
         end
      end
   end

endmodule // pfs_status_regs
`default_nettype wire

// *** bench/pfs_host.sv ***
`timescale 1ns/100ps
`default_nettype none
// ============
// Host side of the command port
module pfs_host
(
   // Clock
   input wire logic clk_i,
   // Command port
   output logic rd_o,
   output logic wr_o,
   output logic [7:0] cmd_o,
   output logic [0:0] page_o
);
   // Quiet port before the first request
   initial {rd_o, wr_o, cmd_o, page_o} = 11'h000;
   // One-cycle write attempt, code stays until the next request
   task wr_pulse(input logic [7:0] c, input logic w);
      begin
         wr_o = w;
         cmd_o = c;
         @(posedge clk_i) #1;
         wr_o = 1'h0;
      end
   endtask
   // One-cycle read; code and page scrambled after so stale values cannot pass
   task rd_pulse(input logic [7:0] c, input logic [0:0] p);
      begin
         rd_o = 1'h1;
         cmd_o = c;
         page_o = p;
         @(posedge clk_i) #1;
         rd_o = 1'h0;
         cmd_o = ~c;
         page_o = ~p;
      end
   endtask
endmodule // pfs_host
`default_nettype wire

// *** bench/pfs_status_regs_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
// ============
// Port-level checks of the status bank
module pfs_status_regs_asserts
(
   // Clock and reset
   input wire clk_i,
   input wire srst_i,
   // Command port
   input wire rd_i,
   input wire wr_i,
   input wire [7:0] cmd_i,
   // Answers
   input wire rd_valid_o,
   input wire rd_hit_o,
   input wire [1:0] rd_len_o,
   input wire [15:0] rd_data_o,
   input wire ro_write_err_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // Word view decoded only on a two-byte answer
   wire word_ok = rd_valid_o && rd_len_o == 2'h2;
   // Write attempt aimed at one of the status codes
   wire own_cmd = cmd_i inside {[8'h78:8'h7C]};
   property p_valid; rd_i |=> rd_valid_o ##1 !rd_valid_o || $past(rd_i, 1); endproperty
   a_valid: assert property (p_valid) else $error("read answer missing");
   property p_word; rd_i && cmd_i == 8'h79 |=> rd_hit_o && rd_len_o == 2'h2; endproperty
   a_word: assert property (p_word) else $error("word length wrong");
   property p_byte; rd_i && cmd_i inside {8'h78, 8'h7A, 8'h7B, 8'h7C} |=>
      rd_len_o == 2'h1 && rd_data_o[15:8] == 8'h00; endproperty
   a_byte: assert property (p_byte) else $error("byte answer wrong");
   property p_werr; wr_i |=> ro_write_err_o == $past(own_cmd); endproperty
   a_werr: assert property (p_werr) else $error("write error flag wrong");
   property p_unused; word_ok |-> !rd_data_o[10] && !rd_data_o[8]; endproperty
   a_unused: assert property (p_unused) else $error("unused bit set");
   property p_other; word_ok && |rd_data_o[15:12] |-> rd_data_o[9]; endproperty
   a_other: assert property (p_other) else $error("other bit clear");
   property p_none; word_ok |-> rd_data_o[0] == (|rd_data_o[15:11] && !(|rd_data_o[7:1]));
   endproperty
   a_none: assert property (p_none) else $error("none-of-above wrong");
   property p_class; word_ok |-> (!rd_data_o[5] || rd_data_o[15]) &&
      (!rd_data_o[4] || rd_data_o[14]) && (!rd_data_o[3] || rd_data_o[13]); endproperty
   a_class: assert property (p_class) else $error("class bit clear");
endmodule // pfs_status_regs_asserts
bind pfs_status_regs pfs_status_regs_asserts pfs_status_regs_asserts_inst (.clk_i(clk_i),
   .srst_i(srst_i), .rd_i(rd_i), .wr_i(wr_i), .cmd_i(cmd_i), .rd_valid_o(rd_valid_o),
   .rd_hit_o(rd_hit_o), .rd_len_o(rd_len_o), .rd_data_o(rd_data_o),
   .ro_write_err_o(ro_write_err_o));
`default_nettype wire

// *** bench/pfs_status_regs_test.sv ***
`timescale 1ns/100ps
`default_nettype none
// ============
// Random fault traffic against a bench model
module pfs_status_regs_test;
   logic clk_i = 1'h0, srst_i = 1'h1, clr = 1'h0, comms_memory_logic_flag = 1'h0, vnd = 1'h0, we;
   logic rd_i, wr_i, rd_valid_o, rd_hit_o, ro_write_err_o;
   logic [0:0] page_i;
   logic [1:0] rd_len_o, off = 2'h0, pg = 2'h0, tmp = 2'h0;
   logic [7:0] cmd_i, c, wc;
   logic [13:0] ev = 14'h0000, m = 14'h0000;
   logic [15:0] rd_data_o;
   logic [31:0] lv, r;
   int n_fail = 0, n_compared = 0, cyc = 0, i;
   pfs_host pfs_host_inst (.clk_i(clk_i), .rd_o(rd_i), .wr_o(wr_i), .cmd_o(cmd_i), .page_o(page_i));
   pfs_status_regs pfs_status_regs_inst (.clk_i(clk_i), .srst_i(srst_i), .rd_i(rd_i), .wr_i(wr_i),
      .cmd_i(cmd_i), .page_i(page_i), .output_overvoltage_fault_i(ev[1:0]), .output_undervoltage_fault_i(ev[3:2]),
      .output_overcurrent_fault_i(ev[5:4]), .output_undercurrent_fault_i(ev[7:6]), .busy_fault_i(ev[9:8]),
      .input_overvoltage_fault_i(ev[13]), .input_overvoltage_warning_i(ev[12]),
      .input_undervoltage_warning_i(ev[11]), .input_undervoltage_fault_i(ev[10]),
      .output_off_i(off), .power_good_i(pg), .temp_any_i(tmp), .comms_memory_logic_flag_i(comms_memory_logic_flag),
      .vendor_class_flag_i(vnd), .clear_faults_i(clr), .rd_valid_o(rd_valid_o),
      .rd_hit_o(rd_hit_o), .rd_len_o(rd_len_o), .rd_data_o(rd_data_o),
      .ro_write_err_o(ro_write_err_o));
   // Expected {valid, hit, len, data}; latched bits from m, live ones from the flag inputs
   function automatic logic [19:0] expect_rd(input logic [7:0] k, input logic p);
      logic [15:0] w;
      logic [7:0] vo, io, ip;
      begin
         vo = {m[p], 2'h0, m[2 + p], 4'h0};
         io = {m[4 + p], 2'h0, m[6 + p], 4'h0};
         ip = {m[13:10], 4'h0};
         w = {|vo, |io, |ip, vnd, ~pg[p], 1'h0, |{vo, io, ip, tmp[p], comms_memory_logic_flag, vnd}, 1'h0,
            m[8 + p], off[p], m[p], m[4 + p], m[10], tmp[p], comms_memory_logic_flag, 1'h0};
         w[0] = |w[15:11] & ~|w[7:1];
         case (k)
            8'h78: expect_rd = {4'hD, 8'h00, w[7:0]};
            8'h79: expect_rd = {4'hE, w};
            8'h7A: expect_rd = {4'hD, 8'h00, vo};
            8'h7B: expect_rd = {4'hD, 8'h00, io};
            8'h7C: expect_rd = {4'hD, 8'h00, ip};
            default: expect_rd = 20'h80000;
         endcase
      end
   endfunction
   // One comparison, counted
   task chk(input logic [19:0] g, e);
      begin
         n_compared++;
         if (g !== e)
         begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
         end
      end
   endtask
   // Counts, verdict, end of run
   task give_verdict;
      begin
         $display("compared %0d failed %0d", n_compared, n_fail);
         if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // Clock
   initial forever #2 clk_i = ~clk_i;
   // Hang guard, well above the 1200 cycles of traffic
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_fail++;
         give_verdict;
      end
   end
   // Events, occasional clear and reset, a write attempt, then a read; first two are the
   // reset value and a single overvoltage event on page 0
   initial
   begin
      r = $urandom(35);
      repeat (8) @(posedge clk_i);
      #1 srst_i = 1'h0;
      for (i = 0; i < 400; i++)
      begin
         // Idle cycle so no port or event signal is driven twice in one time step
         @(posedge clk_i) #1;
         r = $urandom & $urandom & $urandom;
         lv = (i < 2) ? 32'h0000000C : $urandom;
         c = (i < 2) ? 8'h79 : 8'h77 + 8'(lv[18:16]);
         wc = 8'h76 + 8'(lv[22:20]);
         ev = (i < 2) ? 14'(i) : r[13:0];
         clr = r[14] & r[15];
         srst_i = (i > 1) && r[16] && r[17];
         {vnd, comms_memory_logic_flag, tmp, pg, off} = lv[7:0];
         we = lv[8] && !srst_i && wc inside {[8'h78:8'h7C]};
         m = srst_i ? 14'h0000 : (m & ~{14{clr}}) | ev;
         pfs_host_inst.wr_pulse(wc, lv[8]);
         chk({19'h00000, ro_write_err_o}, {19'h00000, we});
         ev = 14'h0000;
         clr = 1'h0;
         srst_i = 1'h0;
         pfs_host_inst.rd_pulse(c, lv[9]);
         chk({rd_valid_o, rd_hit_o, rd_len_o, rd_data_o}, expect_rd(c, lv[9]));
      end
      give_verdict;
   end
endmodule // pfs_status_regs_test
`default_nettype wire
